// *** drr_pkg.sv ***
package drr_pkg;
    // register indexes (printed offsets are not all multiples of four: byte address is index times four)
    localparam logic [7:0]  DRR_IDX_START_LO   = 8'h0C;
    localparam logic [7:0]  DRR_IDX_START_HI   = 8'h0D;
    localparam logic [7:0]  DRR_IDX_ROT_CTRL   = 8'h1B;
    localparam logic [7:0]  DRR_IDX_STRIDE     = 8'h1C;
    localparam logic [7:0]  DRR_IDX_MODE1      = 8'h02;
    localparam logic [7:0]  DRR_IDX_SPLIT      = 8'h20;
    localparam logic [7:0]  DRR_IDX_STATUS     = 8'h21;
    localparam logic [7:0]  DRR_IDX_VGEOM      = 8'h22;
    // field positions
    localparam int          DRR_BIT_ROT_EN     = 7;
    localparam int          DRR_BIT_ROT_ALT    = 6;
    localparam int          DRR_BIT_CLK_HALF   = 4;
    localparam int          DRR_BIT_PCS_LO     = 0;
    localparam int          DRR_BIT_PCS_HI     = 1;
    // reset values
    localparam logic [7:0]  DRR_RST_BYTE       = 8'h00;
    localparam logic [1:0]  DRR_RESP_OKAY      = 2'b00;
    localparam logic [1:0]  DRR_RESP_SLVERR    = 2'b10;
    // geometry defaults
    localparam logic [9:0]  DRR_RST_LINES      = 10'h0EF;
    localparam logic [7:0]  DRR_RST_LINE_BYTES = 8'h77;
    // clock select codes: 0 none, 1 /2, 2 /4, 3 /8
    typedef enum logic [1:0] {
        DRR_DIV_1 = 2'b00,
        DRR_DIV_2 = 2'b01,
        DRR_DIV_4 = 2'b10,
        DRR_DIV_8 = 2'b11
    } drr_div_t;
    // quadrant labels in host write order
    typedef enum logic [1:0] {
        DRR_Q_A = 2'b00,
        DRR_Q_B = 2'b01,
        DRR_Q_C = 2'b10,
        DRR_Q_D = 2'b11
    } drr_quad_t;
endpackage : drr_pkg

// *** drr_clkgen.sv ***
`timescale 1ns/100ps
// derives pixel and memory clock enables from the system clock
module drr_clkgen (
    input  wire logic       sys_clk,   // system clock
    input  wire logic       rst_n,     // async reset, active low
    input  wire logic       clk_half,  // operating clock is input halved
    input  wire logic       rot_en,    // rotated refresh active
    input  wire logic       rot_alt,   // alternate scheme
    input  wire logic [1:0] pix_sel,   // extra rotated divide select
    output logic            mclk_en,   // memory clock tick
    output logic            pclk_en    // pixel clock tick
);
    logic [4:0] cnt_reg;
    logic [4:0] mask;
    logic       op_tick;
    logic       pix_toggle_reg;

    ////////////////////////////////////////////////////////////////////////
    // divide mask: halve (RL10), then extra rotated divide (RL11)
    always_comb begin
        mask = {4'h0, clk_half};                        // RL10
        if (rot_en) begin
            case (drr_pkg::drr_div_t'(pix_sel))         // RL11
                drr_pkg::DRR_DIV_1: mask = {4'h0, clk_half};
                drr_pkg::DRR_DIV_2: mask = {3'h0, clk_half, 1'b1};
                drr_pkg::DRR_DIV_4: mask = {2'h0, clk_half, 2'h3};
                drr_pkg::DRR_DIV_8: mask = {1'h0, clk_half, 3'h7};
                default:            mask = {4'h0, clk_half};
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 5'h00;
        end else if ((cnt_reg & mask) == mask) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    assign op_tick = ((cnt_reg & mask) == mask);

    ////////////////////////////////////////////////////////////////////////
    // alternate: pixel every second memory tick (RL9, RL16); else equal (RL8)
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_toggle_reg <= 1'b0;
            mclk_en        <= 1'b0;
            pclk_en        <= 1'b0;
        end else begin
            mclk_en <= op_tick;
            if (op_tick) begin
                pix_toggle_reg <= ~pix_toggle_reg;
            end
            pclk_en <= op_tick && (!(rot_en && rot_alt) || pix_toggle_reg); // RL8 RL9 RL16
        end
    end
endmodule : drr_clkgen

// *** drr_addrgen.sv ***
`timescale 1ns/100ps
// fetch address generator for one frame
module drr_addrgen #(
    parameter int AW = 16                          // address width
) (
    input  wire logic          sys_clk,     // system clock
    input  wire logic          rst_n,       // async reset, active low
    input  wire logic          frame_start, // restart at frame start
    input  wire logic          step,        // advance one pixel byte
    input  wire logic          rot_en,      // rotated frame
    input  wire logic [14:0]   start_off,   // start offset
    input  wire logic [7:0]    stride,      // rotated line stride bytes
    input  wire logic [7:0]    line_bytes,  // bytes in one line, minus one
    output logic [AW-1:0]      addr,        // current byte address
    output logic               line_end     // last byte of line
);
    logic [AW-1:0] line_base_reg;
    logic [7:0]    col_reg;
    logic [AW-1:0] start_bytes;
    logic [AW-1:0] pitch;

    ////////////////////////////////////////////////////////////////////////
    // rotated: offset is bytes (RL3); landscape: words, doubled
    assign start_bytes = rot_en ? AW'(start_off) : AW'({start_off, 1'b0}); // RL3
    // rotated pitch is the stride (RL2); landscape ignores it (RL1)
    assign pitch       = rot_en ? AW'(stride) : AW'(line_bytes);           // RL1 RL2
    assign line_end    = (col_reg == line_bytes);
    assign addr        = line_base_reg + AW'(col_reg);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_base_reg <= '0;
            col_reg       <= 8'h00;
        end else if (frame_start) begin
            line_base_reg <= start_bytes;
            col_reg       <= 8'h00;
        end else if (step) begin
            if (line_end) begin
                line_base_reg <= line_base_reg + pitch;                    // RL2
                col_reg       <= 8'h00;
            end else begin
                col_reg <= col_reg + 8'h01;
            end
        end
    end
endmodule : drr_addrgen

// *** drr_top.sv ***
`timescale 1ns/100ps
// Function
// (RL1) enable bit zero: landscape refresh, rotation fields and stride ignored
// (RL2) rotated: stride register gives byte distance between line starts
// (RL3) rotated: fifteen-bit start offset is a byte address
// (RL4) scheme select bit picks default or alternate rotation scheme
// (RL5) host programs power-of-two rotated width in default scheme
// (RL6) default scheme scrolls vertically in two-line steps
// (RL7) alternate scheme accepts any width and single-line scrolling
// (RL8) default scheme: memory clock at least pixel clock
// (RL9) alternate scheme: memory clock at least twice pixel clock
// (RL10) operating clock is input clock, optionally halved by mode bit 4
// (RL11) rotated: extra divide of none, 2, 4 or 8
// (RL12) rotated refresh fetches quadrants in order B, D, A, C
// (RL13) host picks default scheme only if image fits the buffer
// (RL14) writing 80h enables rotation, default scheme, enable at bit 7
// (RL15) writing C0h enables alternate scheme, select at bit 6
// (RL16) alternate scheme with select bits untouched: pixel clock half rate
// (RL17) split screen is suppressed while rotated
// (RL18) settings take effect at the next frame start; mode bit 4 and the geometry register here apply at once
module drr_top #(
    parameter int AW = 16                          // fetch address width
) (
    input  wire logic          sys_clk,        // system clock 40 MHz
    input  wire logic          rst_n,          // async reset, active low
    input  wire logic          s_axi_awvalid,  // write address valid
    output logic               s_axi_awready,  // write address ready
    input  wire logic [31:0]   s_axi_awaddr,   // write address
    input  wire logic          s_axi_wvalid,   // write data valid
    output logic               s_axi_wready,   // write data ready
    input  wire logic [31:0]   s_axi_wdata,    // write data
    input  wire logic [3:0]    s_axi_wstrb,    // write strobes
    output logic               s_axi_bvalid,   // write response valid
    input  wire logic          s_axi_bready,   // write response ready
    output logic [1:0]         s_axi_bresp,    // write response
    input  wire logic          s_axi_arvalid,  // read address valid
    output logic               s_axi_arready,  // read address ready
    input  wire logic [31:0]   s_axi_araddr,   // read address
    output logic               s_axi_rvalid,   // read data valid
    input  wire logic          s_axi_rready,   // read data ready
    output logic [31:0]        s_axi_rdata,    // read data
    output logic [1:0]         s_axi_rresp,    // read response
    input  wire logic          frame_sync,     // frame boundary pulse, same clock
    output logic [AW-1:0]      fetch_addr,     // display memory byte address
    output logic               fetch_valid,    // fetch address valid
    output logic [1:0]         fetch_quad,     // quadrant being refreshed
    output logic               pclk_tick,      // pixel clock tick
    output logic               mclk_tick,      // memory clock tick
    output logic               rotated,        // rotated mode active
    output logic               split_active    // split screen in use
);
    // software copies
    logic [7:0]  start_lo_reg;
    logic [6:0]  start_hi_reg;
    logic [7:0]  rot_ctrl_reg;
    logic [7:0]  stride_reg;
    logic        clk_half_reg;
    logic        split_en_reg;
    logic [9:0]  lines_reg;
    logic [7:0]  line_bytes_reg;
    // frame-applied copies
    logic [14:0] act_start_reg;
    logic [7:0]  act_rot_reg;
    logic [7:0]  act_stride_reg;
    logic        act_split_reg;
    // bus state
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_idx_reg;
    logic [31:0] w_data_reg;
    logic        w_strb0_reg;
    logic        wr_fire;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  rd_idx;
    logic [31:0] rd_val;
    // refresh state
    logic        frame_pend_reg;
    logic [9:0]  line_cnt_reg;
    logic [1:0]  band;
    logic [1:0]  quad_reg;
    logic        mclk_en;
    logic        pclk_en;
    logic [AW-1:0] ag_addr;
    logic        ag_line_end;
    logic        act_en;
    logic        act_alt;
    logic [14:0] eff_start;

    ////////////////////////////////////////////////////////////////////////
    // write channel: accept address and data in either order
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_idx_reg    <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb0_reg   <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= drr_pkg::DRR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_idx_reg    <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data_reg   <= s_axi_wdata;
                w_strb0_reg  <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? drr_pkg::DRR_RESP_OKAY : drr_pkg::DRR_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held_reg   <= 1'b0;
                w_held_reg    <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // decode of write target
    always_comb begin
        case (aw_idx_reg)
            drr_pkg::DRR_IDX_START_LO, drr_pkg::DRR_IDX_START_HI,
            drr_pkg::DRR_IDX_ROT_CTRL, drr_pkg::DRR_IDX_STRIDE,
            drr_pkg::DRR_IDX_MODE1,    drr_pkg::DRR_IDX_SPLIT,
            drr_pkg::DRR_IDX_VGEOM:    wr_hit = 1'b1;
            default:                   wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage; writes happen only when the byte lane 0 strobe is set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_lo_reg   <= drr_pkg::DRR_RST_BYTE;
            start_hi_reg   <= 7'h00;
            rot_ctrl_reg   <= drr_pkg::DRR_RST_BYTE;
            stride_reg     <= drr_pkg::DRR_RST_BYTE;
            clk_half_reg   <= 1'b0;
            split_en_reg   <= 1'b0;
            lines_reg      <= drr_pkg::DRR_RST_LINES;
            line_bytes_reg <= drr_pkg::DRR_RST_LINE_BYTES;
        end else if (wr_fire && w_strb0_reg) begin
            case (aw_idx_reg)
                drr_pkg::DRR_IDX_START_LO: start_lo_reg <= w_data_reg[7:0];
                drr_pkg::DRR_IDX_START_HI: start_hi_reg <= w_data_reg[6:0];
                // 80h default, C0h alternate (RL4 RL14 RL15)
                drr_pkg::DRR_IDX_ROT_CTRL: rot_ctrl_reg <= {w_data_reg[7:6], 4'h0,
                                                            w_data_reg[1:0]}; // RL14 RL15
                drr_pkg::DRR_IDX_STRIDE:   stride_reg   <= w_data_reg[7:0];
                drr_pkg::DRR_IDX_MODE1:    clk_half_reg <= w_data_reg[drr_pkg::DRR_BIT_CLK_HALF];
                drr_pkg::DRR_IDX_SPLIT:    split_en_reg <= w_data_reg[0];
                drr_pkg::DRR_IDX_VGEOM:    begin
                    lines_reg      <= w_data_reg[9:0];
                    line_bytes_reg <= w_data_reg[23:16];
                end
                default:                   start_lo_reg <= start_lo_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel, one cycle after address is taken
    assign rd_idx = s_axi_araddr[9:2];

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (rd_idx)
            drr_pkg::DRR_IDX_START_LO: rd_val = {24'h0, start_lo_reg};
            drr_pkg::DRR_IDX_START_HI: rd_val = {25'h0, start_hi_reg};
            drr_pkg::DRR_IDX_ROT_CTRL: rd_val = {24'h0, rot_ctrl_reg};
            drr_pkg::DRR_IDX_STRIDE:   rd_val = {24'h0, stride_reg};
            drr_pkg::DRR_IDX_MODE1:    rd_val = {27'h0, clk_half_reg, 4'h0};
            drr_pkg::DRR_IDX_SPLIT:    rd_val = {31'h0, split_en_reg};
            drr_pkg::DRR_IDX_VGEOM:    rd_val = {8'h0, line_bytes_reg, 6'h0, lines_reg};
            drr_pkg::DRR_IDX_STATUS:   rd_val = {12'h0, 2'(quad_reg), line_cnt_reg,
                                                 5'h0, act_split_reg, act_rot_reg[6],
                                                 act_rot_reg[7]};
            default: begin
                rd_hit = 1'b0;
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= drr_pkg::DRR_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_hit ? drr_pkg::DRR_RESP_OKAY : drr_pkg::DRR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settings copied only at a frame boundary so no frame mixes them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_start_reg  <= 15'h0000;
            act_rot_reg    <= drr_pkg::DRR_RST_BYTE;
            act_stride_reg <= drr_pkg::DRR_RST_BYTE;
            act_split_reg  <= 1'b0;
        end else if (frame_sync) begin
            act_start_reg  <= {start_hi_reg, start_lo_reg};                 // RL18
            act_rot_reg    <= rot_ctrl_reg;                                 // RL18
            act_stride_reg <= stride_reg;                                   // RL18
            // rotation excludes split screen
            act_split_reg  <= split_en_reg && !rot_ctrl_reg[drr_pkg::DRR_BIT_ROT_EN]; // RL17
        end
    end

    assign act_en  = act_rot_reg[drr_pkg::DRR_BIT_ROT_EN];                   // RL1
    assign act_alt = act_en && act_rot_reg[drr_pkg::DRR_BIT_ROT_ALT];        // RL4
    // default scheme drops the low line step: scroll in pairs of lines
    assign eff_start = (act_en && !act_alt) ?
                       (act_start_reg & ~{7'h00, act_stride_reg}) : act_start_reg; // RL6 RL7

    ////////////////////////////////////////////////////////////////////////
    // clock derivation; the extra divide is ignored in landscape
    drr_clkgen u_clkgen (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_half (clk_half_reg),                                           // RL10
        .rot_en   (act_en),
        .rot_alt  (act_alt),
        .pix_sel  (act_rot_reg[drr_pkg::DRR_BIT_PCS_HI:drr_pkg::DRR_BIT_PCS_LO]),
        .mclk_en  (mclk_en),
        .pclk_en  (pclk_en)
    );

    drr_addrgen #(.AW(AW)) u_addrgen (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .frame_start (frame_pend_reg),
        .step        (pclk_en),
        .rot_en      (act_en),
        .start_off   (eff_start),
        .stride      (act_stride_reg),
        .line_bytes  (line_bytes_reg),
        .addr        (ag_addr),
        .line_end    (ag_line_end)
    );

    ////////////////////////////////////////////////////////////////////////
    // line quarter by count; stays in the last band until the next frame, unless the ten-bit line count wraps first
    assign band = (line_cnt_reg >= lines_reg - (lines_reg >> 2)) ? 2'h3 :
                  (line_cnt_reg >= (lines_reg >> 1))             ? 2'h2 :
                  2'(line_cnt_reg >= (lines_reg >> 2));

    // line and quadrant tracking; rotated order B, D, A, C
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_pend_reg <= 1'b0;
            line_cnt_reg   <= 10'h000;
            quad_reg       <= drr_pkg::DRR_Q_A;
        end else begin
            frame_pend_reg <= frame_sync;
            if (frame_pend_reg) begin
                line_cnt_reg <= 10'h000;
            end else if (pclk_en && ag_line_end) begin
                line_cnt_reg <= line_cnt_reg + 10'h001;
            end
            // quarter band of the frame picks the quadrant; landscape keeps write order
            if (!act_en) begin
                quad_reg <= band;
            end else begin
                case (band)
                    2'b00:   quad_reg <= drr_pkg::DRR_Q_B;                  // RL12
                    2'b01:   quad_reg <= drr_pkg::DRR_Q_D;                  // RL12
                    2'b10:   quad_reg <= drr_pkg::DRR_Q_A;                  // RL12
                    2'b11:   quad_reg <= drr_pkg::DRR_Q_C;                  // RL12
                    default: quad_reg <= drr_pkg::DRR_Q_A;
                endcase
            end
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr   <= '0;
            fetch_valid  <= 1'b0;
            fetch_quad   <= 2'b00;
            pclk_tick    <= 1'b0;
            mclk_tick    <= 1'b0;
            rotated      <= 1'b0;
            split_active <= 1'b0;
        end else begin
            fetch_addr   <= ag_addr;
            fetch_valid  <= pclk_en;
            fetch_quad   <= quad_reg;
            pclk_tick    <= pclk_en;
            mclk_tick    <= mclk_en;
            rotated      <= act_en;                                         // RL1
            split_active <= act_split_reg;                                  // RL17
        end
    end
endmodule : drr_top

// *** drr_props.sv ***
`timescale 1ns/100ps
// watches the top ports of the rotation refresh block
module drr_props (
    input wire logic        sys_clk,       // clock
    input wire logic        rst_n,         // reset, active low
    input wire logic        s_axi_arvalid, // read addr valid
    input wire logic        s_axi_arready, // read addr ready
    input wire logic        s_axi_rvalid,  // read data valid
    input wire logic        s_axi_rready,  // read data ready
    input wire logic [31:0] s_axi_rdata,   // read data
    input wire logic        s_axi_bvalid,  // write resp valid
    input wire logic        s_axi_bready,  // write resp ready
    input wire logic        frame_sync,    // frame start
    input wire logic [1:0]  fetch_quad,    // quadrant
    input wire logic        pclk_tick,     // pixel tick
    input wire logic        mclk_tick,     // memory tick
    input wire logic        rotated,       // rotated level
    input wire logic        split_active   // split level
);
    // next quadrant, indexed by current: A to C, B to D, C to B, D to A
    localparam logic [7:0] NXT = 8'h1E;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_split_excl: assert property (rotated |-> !split_active)
        else $error("split screen active while rotated");
    a_pix_mem: assert property (pclk_tick |-> mclk_tick)
        else $error("pixel tick without memory tick");
    a_rot_frame: assert property ($changed(rotated) |-> $past(frame_sync, 2))
        else $error("rotation changed outside frame start");
    a_quad_order: assert property ((!frame_sync)[*4] ##1 (rotated && $past(rotated)
        && fetch_quad != $past(fetch_quad))
        |-> fetch_quad == NXT[2*$past(fetch_quad) +: 2])
        else $error("quadrant refresh order wrong");
    a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    c_rot_pix: cover property (rotated && pclk_tick);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_split: cover property ($rose(split_active));
endmodule : drr_props

bind drr_top drr_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .frame_sync(frame_sync),
    .fetch_quad(fetch_quad), .pclk_tick(pclk_tick), .mclk_tick(mclk_tick),
    .rotated(rotated), .split_active(split_active));

// *** drr_panel_model.sv ***
`timescale 1ns/100ps
// panel stand-in: takes one pixel per tick, logs quadrant order
module drr_panel_model (
    input  wire logic        sys_clk,   // clock
    input  wire logic        clr,       // restart counts
    input  wire logic        pclk_tick, // pixel tick
    input  wire logic        mclk_tick, // memory tick
    input  wire logic        fv,        // pixel fetched
    input  wire logic [1:0]  fq,        // quadrant
    output logic      [31:0] pix,       // pixel ticks seen
    output logic      [31:0] mck,       // memory ticks seen
    output logic      [7:0]  qseq       // last four quadrants
);
    logic first;
    // counts restart on clr so the bench can time a window
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            pix <= '0; mck <= '0; qseq <= '0; first <= 1'b1;
        end else begin
            pix <= pix + 32'(pclk_tick);
            mck <= mck + 32'(mclk_tick);
            if (fv && (first || fq != qseq[1:0])) begin
                qseq <= {qseq[5:0], fq};
                first <= 1'b0;
            end
        end
    end
endmodule : drr_panel_model

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, fs = 0, clr = 0;
    logic awr, wr, bv, arr, rv, rot, spl, pt, mt, fv;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd, pix, mck, d;
    logic [1:0]  br, rr, fq, r;
    logic [15:0] fa;
    logic [7:0]  qseq;
    int mismatches = 0, check_count = 0, cyc = 0;
    drr_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .frame_sync(fs),
        .fetch_addr(fa), .fetch_valid(fv), .fetch_quad(fq), .pclk_tick(pt),
        .mclk_tick(mt), .rotated(rot), .split_active(spl));
    drr_panel_model u_panel (.sys_clk(sys_clk), .clr(clr), .pclk_tick(pt), .mclk_tick(mt),
        .fv(fv), .fq(fq), .pix(pix), .mck(mck), .qseq(qseq));
    initial forever #12.5 sys_clk = ~sys_clk;
    // hang guard: all tests fit well inside this
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin mismatches++; wrap_up(); end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr32(input logic [31:0] a, input logic [31:0] v);
        @(posedge sys_clk); awv <= 1; wv <= 1; awa <= a; wd <= v; bre <= 1;
        fork
            begin do @(posedge sys_clk); while (!awr); awv <= 0; end
            begin do @(posedge sys_clk); while (!wr); wv <= 0; end
        join
        do @(posedge sys_clk); while (!bv);
        r = br;
        bre <= 0;
    endtask : wr32
    task rd32(input logic [31:0] a);
        @(posedge sys_clk); arv <= 1; ara <= a; rre <= 1;
        do @(posedge sys_clk); while (!arr);
        arv <= 0;
        do @(posedge sys_clk); while (!rv);
        d = rd; r = rr; rre <= 0;
    endtask : rd32
    // frame start pulse; panel counts restart with it
    task frame;
        @(posedge sys_clk); fs <= 1; clr <= 1;
        @(posedge sys_clk); fs <= 0; clr <= 0;
    endtask : frame
    task wrap_up;
        $display("mismatches=%0d checks=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1;
        rd32(32'h88); chk(d, 32'h0077_00EF);
        rd32(32'h00); chk({30'h0, r}, 32'h2); chk(d, 32'h0);
        wr32(32'h6C, 32'hFF); rd32(32'h6C); chk(d, 32'hC3);
        chk(rot, 0);
        // small frame of 8 lines by 9 bytes keeps the run short
        wr32(32'h88, 32'h0008_0008); wr32(32'h30, 32'h7F); wr32(32'h34, 32'h00);
        wr32(32'h70, 32'h80); wr32(32'h80, 32'h1); wr32(32'h6C, 32'h80);
        frame;
        repeat (3) @(posedge sys_clk);
        chk(fa, 16'h007F);
        chk(rot, 1);
        chk(spl, 0);
        chk(fv, 1);
        repeat (600) @(posedge sys_clk);
        chk(qseq, 8'h72);
        chk(32'(pix <= mck), 1);
        for (int s = 0; s < 4; s++) begin
            wr32(32'h6C, 32'hC0 | s); frame; repeat (256) @(posedge sys_clk);
            chk(32'(pix + 1 >= (128 >> s) && pix <= (128 >> s) + 1), 1);
            chk(32'(mck + 1 >= 2 * pix), 1);
        end
        wr32(32'h6C, 32'hC0); wr32(32'h08, 32'h10); frame; repeat (256) @(posedge sys_clk);
        chk(32'(pix >= 63 && pix <= 65), 1);
        wr32(32'h6C, 32'h00); frame; repeat (2) @(posedge sys_clk);
        chk(rot, 0);
        chk(spl, 1);
        chk({30'h0, r}, 32'h0);
        wrap_up();
    end
endmodule : tb_top
